// [common/lswd_pkg.sv]
// Package of constants and types for the low-speed watchdog timer
package lswd_pkg;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int unsigned TIMEOUT_OSC_PERIODS = 131072;
   localparam int unsigned OSC_TICK_DIV        = 128;
   localparam int unsigned TICKS_TO_OVF        = TIMEOUT_OSC_PERIODS / OSC_TICK_DIV;
   localparam int unsigned CNT_W               = $clog2(TICKS_TO_OVF);
   localparam logic [CNT_W-1:0] CNT_MAX        = CNT_W'(TICKS_TO_OVF - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO       = CNT_W'(0);

   // ==========================================================
   // Register map: indices, byte address is four times index
   // ==========================================================
   localparam int unsigned ADDR_W  = 32;
   localparam int unsigned DATA_W  = 32;
   localparam logic [29:0] CTL_IDX = 30'h0000_5040;
   localparam logic [29:0] ST_IDX  = 30'h0000_5041;

   // ==========================================================
   // Fields and reset values
   // ==========================================================
   localparam int unsigned CTL_KICK_BIT = 4;
   localparam int unsigned ST_MODE_BIT  = 1;
   localparam int unsigned ST_OVF_BIT   = 0;
   localparam logic [3:0] KEY_STOP      = 4'hA;
   localparam logic       MODE_NMI      = 1'h0;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control register image as software sees it
   typedef struct packed {
      logic [2:0] rsv;
      logic       kick_bit;
      logic [3:0] run_stop_key;
   } lswd_ctl_s;

   // Status register image as software sees it
   typedef struct packed {
      logic [5:0] rsv;
      logic       overflow_action_select;
      logic       overflow_status_bit;
   } lswd_st_s;

endpackage : lswd_pkg

// [dv/lswd_cpu_model.sv]
// CPU-side model that takes the watchdog NMI and reset requests
`timescale 1ns/100ps
`default_nettype none
module lswd_cpu_model (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic nmi_req,
   input  wire logic sys_reset_req,
   output logic [7:0] nmi_count,
   output logic [7:0] rst_count,
   output logic       cpu_reset
);
   // ====================
   // Request intake
   // ====================
   // Reset request comes back as a one-cycle system reset, so the
   // block is no better off than behind a real reset controller
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         nmi_count <= 8'h00;
         rst_count <= 8'h00;
         cpu_reset <= 1'b0;
      end else begin
         nmi_count <= nmi_count + {7'h00, nmi_req};
         rst_count <= rst_count + {7'h00, sys_reset_req};
         cpu_reset <= sys_reset_req;
      end
   end
endmodule : lswd_cpu_model
`default_nettype wire

// [dv/lswd_watchdog_tb.sv]
// Self-checking bench for the low-speed watchdog timer
`timescale 1ns/100ps
`default_nettype none
module lswd_watchdog_tb;
   localparam logic [31:0] CA   = {lswd_pkg::CTL_IDX, 2'h0};
   localparam logic [31:0] SA   = {lswd_pkg::ST_IDX, 2'h0};
   localparam logic [31:0] KICK = 32'h10;
   logic        sys_clk, bench_rst, osc_tick, cpu_reset;
   logic [31:0] awaddr, wdata, araddr, rdata, seed;
   logic [3:0]  wstrb, key;
   logic [1:0]  bresp, rresp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, nmi, sreq, mode;
   logic [7:0]  nmi_cnt, rst_cnt;
   int          mismatches, total_checks, cycles;
   wire logic   reset = bench_rst | cpu_reset;

   always #20 sys_clk = ~sys_clk;

   lswd_watchdog dut (
      .sys_clk(sys_clk), .reset(reset), .osc_tick(osc_tick),
      .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
      .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
      .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
      .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
      .s_axil_rvalid(rvalid), .s_axil_rready(rready), .nmi_req(nmi),
      .sys_reset_req(sreq)
   );
   lswd_cpu_model cpu (
      .sys_clk(sys_clk), .reset(bench_rst), .nmi_req(nmi), .sys_reset_req(sreq),
      .nmi_count(nmi_cnt), .rst_count(rst_cnt), .cpu_reset(cpu_reset)
   );

   // ====================
   // Expectations and compares
   // ====================
   function automatic logic [31:0] ctl_exp(input logic [3:0] k);
      lswd_pkg::lswd_ctl_s c;
      c = '0;
      c.run_stop_key = k;
      return 32'(c);
   endfunction : ctl_exp

   function automatic logic [31:0] st_exp(input logic m, input logic o);
      lswd_pkg::lswd_st_s s;
      s = '0;
      s.overflow_action_select = m;
      s.overflow_status_bit = o;
      return 32'(s);
   endfunction : st_exp

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic cnt(input logic [7:0] en, input logic [7:0] er);
      chk(32'(nmi_cnt), 32'(en));
      chk(32'(rst_cnt), 32'(er));
   endtask : cnt

   // ====================
   // Bus master
   // ====================
   // Handshakes are sampled at the falling edge, where outputs are settled,
   // and acted on by non-blocking assignment at the following rising edge
   task automatic wchk(input logic [31:0] a, input logic [31:0] d,
                       input logic [1:0] e = lswd_pkg::RESP_OKAY);
      logic da, dw, ta, tw;
      logic [1:0] r;
      da = 1'b0;
      dw = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(da && dw)) begin
         @(negedge sys_clk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         @(posedge sys_clk);
         da = da | ta;
         dw = dw | tw;
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      ta = 1'b0;
      while (!ta) begin
         @(negedge sys_clk);
         ta = bvalid;
         r = bresp;
         @(posedge sys_clk);
      end
      bready <= 1'b0;
      chk(32'(r), 32'(e));
      // One idle edge so a following call never re-raises bready in this step
      @(posedge sys_clk);
   endtask : wchk

   task automatic rchk(input logic [31:0] a, input logic [31:0] e,
                       input logic [1:0] er = lswd_pkg::RESP_OKAY);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 1'b0;
      while (!t) begin
         @(negedge sys_clk);
         t = arready;
         @(posedge sys_clk);
      end
      arvalid <= 1'b0;
      t = 1'b0;
      while (!t) begin
         @(negedge sys_clk);
         t = rvalid;
         d = rdata;
         r = rresp;
         @(posedge sys_clk);
      end
      rready <= 1'b0;
      chk(d, e);
      chk(32'(r), 32'(er));
      @(posedge sys_clk);
   endtask : rchk

   // Eight clocks a tick keeps well clear of the three-stage synchroniser
   task automatic ticks(input int n);
      repeat (n) begin
         osc_tick <= 1'b1;
         repeat (4) @(posedge sys_clk);
         osc_tick <= 1'b0;
         repeat (4) @(posedge sys_clk);
      end
      repeat (8) @(posedge sys_clk);
   endtask : ticks

   task automatic final_report();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 80000) begin
         mismatches++;
         final_report();
      end
   end

   // ====================
   // Main sequence
   // ====================
   initial begin
      sys_clk = 1'b0;
      bench_rst = 1'b1;
      osc_tick = 1'b0;
      awaddr = '0;
      wdata = '0;
      araddr = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      seed = 32'h8393;
      repeat (4) @(posedge sys_clk);
      bench_rst <= 1'b0;
      @(posedge sys_clk);
      rchk(CA, ctl_exp(lswd_pkg::KEY_STOP));
      rchk(SA, st_exp(lswd_pkg::MODE_NMI, 1'b0));
      ticks(1100);
      cnt(8'h00, 8'h00);
      repeat (8) begin
         key = 4'($random(seed));
         mode = 1'($random(seed));
         wchk(CA, ctl_exp(key));
         wchk(SA, st_exp(mode, 1'b0));
         rchk(CA, ctl_exp(key));
         rchk(SA, st_exp(mode, 1'b0));
      end
      // Word just past the status register is unmapped
      wchk(SA + 32'h4, 32'h0, lswd_pkg::RESP_SLVERR);
      rchk(SA + 32'h4, 32'h0, lswd_pkg::RESP_SLVERR);
      key = 4'($random(seed));
      if (key == lswd_pkg::KEY_STOP) key = 4'h5;
      wchk(SA, st_exp(lswd_pkg::MODE_NMI, 1'b0));
      wchk(CA, ctl_exp(key) | KICK);
      rchk(CA, ctl_exp(key));
      ticks(600);
      wchk(CA, ctl_exp(key) | KICK);
      ticks(1023);
      cnt(8'h00, 8'h00);
      ticks(1);
      cnt(8'h01, 8'h00);
      rchk(SA, st_exp(1'b0, 1'b1));
      ticks(1023);
      cnt(8'h01, 8'h00);
      ticks(1);
      cnt(8'h02, 8'h00);
      wchk(CA, ctl_exp(key) | KICK);
      rchk(SA, st_exp(1'b0, 1'b0));
      // Stopped key and an idle tick both hold the count
      ticks(500);
      wchk(CA, ctl_exp(lswd_pkg::KEY_STOP));
      ticks(1000);
      repeat (200) @(posedge sys_clk);
      wchk(CA, ctl_exp(key));
      ticks(523);
      cnt(8'h02, 8'h00);
      ticks(1);
      cnt(8'h03, 8'h00);
      // Reset mode: the returned system reset wipes the status
      wchk(SA, st_exp(1'b1, 1'b0));
      wchk(CA, ctl_exp(key) | KICK);
      ticks(1024);
      cnt(8'h03, 8'h01);
      rchk(SA, st_exp(1'b0, 1'b0));
      rchk(CA, ctl_exp(lswd_pkg::KEY_STOP));
      final_report();
   end
endmodule : lswd_watchdog_tb
`default_nettype wire

// [rtl/lswd_tick_sync.sv]
// Three-stage synchroniser with rise detect for the oscillator tick
`timescale 1ns/100ps
`default_nettype none
module lswd_tick_sync (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic tick_async,
   output logic      tick_rise
);
   logic [2:0] sync_reg;
   logic       level_reg;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sync_reg <= 3'h0;
      end else begin
         sync_reg <= {sync_reg[1:0], tick_async};
      end
   end

   // A change counts only once stages two and three agree
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         level_reg <= 1'h0;
      end else if (sync_reg[1] == sync_reg[2]) begin
         level_reg <= sync_reg[2];
      end
   end

   assign tick_rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2] && !level_reg;
endmodule : lswd_tick_sync
`default_nettype wire

// [rtl/lswd_up_counter.sv]
// Up-counter with clear and wrap pulse
`timescale 1ns/100ps
`default_nettype none
module lswd_up_counter #(
   parameter int unsigned W = 10
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic         step,
   input  wire logic         clear,
   output logic [W-1:0]      count,
   output logic              wrap
);
   logic [W-1:0] count_reg;

   assign wrap  = step && (count_reg == {W{1'b1}});
   assign count = count_reg;

   // Clear wins over a step in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         count_reg <= '0;
      end else if (clear) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + W'(1);
      end
   end
endmodule : lswd_up_counter
`default_nettype wire

// [rtl/lswd_watchdog.sv]
// Low-speed watchdog timer with AXI4-Lite register access
// ==========================================================
// ==========================================================
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module lswd_watchdog (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        osc_tick,
   input  wire logic [31:0] s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   input  wire logic [31:0] s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready,
   output logic             nmi_req,
   output logic             sys_reset_req
);

   // ==========================================================
   // Tick and counter
   // ==========================================================
   logic                         tick_rise;
   logic [lswd_pkg::CNT_W-1:0]   count;
   logic                         wrap;
   logic                         run;
   logic                         kick;
   logic                         ovf;
   logic [3:0]                   key_reg;
   logic                         mode_reg;
   logic                         status_reg;
   logic                         nmi_reg;
   logic                         rst_reg;

   // The oscillator tick has no enable of its own: halt keeps it, sleep stops it
   lswd_tick_sync u_sync (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .tick_async (osc_tick),
      .tick_rise  (tick_rise)
   );

   assign run = (key_reg != lswd_pkg::KEY_STOP);

   lswd_up_counter #(
      .W (lswd_pkg::CNT_W)
   ) u_cnt (
      .sys_clk (sys_clk),
      .reset   (reset),
      .step    (tick_rise && run),
      .clear   (kick),
      .count   (count),
      .wrap    (wrap)
   );

   // Overflow still fires in a kick cycle so it is never lost
   assign ovf = wrap;

   // ==========================================================
   // Overflow outputs
   // ==========================================================
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         nmi_reg <= 1'h0;
         rst_reg <= 1'h0;
      end else begin
         nmi_reg <= ovf && (mode_reg == lswd_pkg::MODE_NMI);
         rst_reg <= ovf && (mode_reg != lswd_pkg::MODE_NMI);
      end
   end

   assign nmi_req       = nmi_reg;
   assign sys_reset_req = rst_reg;

   // Set beats a kick arriving in the same cycle
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status_reg <= 1'h0;
      end else if (ovf) begin
         status_reg <= 1'h1;
      end else if (kick) begin
         status_reg <= 1'h0;
      end
   end

   // ==========================================================
   // AXI4-Lite write channel
   // ==========================================================
   logic                 awready_reg;
   logic                 wready_reg;
   logic                 bvalid_reg;
   logic [1:0]           bresp_reg;
   logic [29:0]          waddr_reg;
   logic [7:0]           wdata_reg;
   logic                 wlane_reg;
   logic                 wr_go;
   logic                 wr_ctl;
   logic                 wr_st;
   lswd_pkg::lswd_ctl_s  wctl;
   lswd_pkg::lswd_st_s   wst;

   assign wr_go  = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_ctl = wr_go && wlane_reg && (waddr_reg == lswd_pkg::CTL_IDX);
   assign wr_st  = wr_go && wlane_reg && (waddr_reg == lswd_pkg::ST_IDX);
   assign wctl   = wdata_reg;
   assign wst    = wdata_reg;
   assign kick   = wr_ctl && wctl.kick_bit;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         awready_reg <= 1'h1;
         waddr_reg   <= '0;
      end else if (s_axil_awvalid && awready_reg) begin
         awready_reg <= 1'h0;
         waddr_reg   <= s_axil_awaddr[31:2];
      end else if (bvalid_reg && s_axil_bready) begin
         awready_reg <= 1'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wready_reg <= 1'h1;
         wdata_reg  <= '0;
         wlane_reg  <= 1'h0;
      end else if (s_axil_wvalid && wready_reg) begin
         wready_reg <= 1'h0;
         wdata_reg  <= s_axil_wdata[7:0];
         wlane_reg  <= s_axil_wstrb[0];
      end else if (bvalid_reg && s_axil_bready) begin
         wready_reg <= 1'h1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bvalid_reg <= 1'h0;
         bresp_reg  <= lswd_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'h1;
         bresp_reg  <= (waddr_reg == lswd_pkg::CTL_IDX || waddr_reg == lswd_pkg::ST_IDX)
                       ? lswd_pkg::RESP_OKAY : lswd_pkg::RESP_SLVERR;
      end else if (s_axil_bready) begin
         bvalid_reg <= 1'h0;
      end
   end

   // Key and mode; reserved and kick bits are not stored
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         key_reg <= lswd_pkg::KEY_STOP;
      end else if (wr_ctl) begin
         key_reg <= wctl.run_stop_key;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mode_reg <= lswd_pkg::MODE_NMI;
      end else if (wr_st) begin
         mode_reg <= wst.overflow_action_select;
      end
   end

   assign s_axil_awready = awready_reg;
   assign s_axil_wready  = wready_reg;
   assign s_axil_bvalid  = bvalid_reg;
   assign s_axil_bresp   = bresp_reg;

   // ==========================================================
   // AXI4-Lite read channel
   // ==========================================================
   logic                 arready_reg;
   logic                 rvalid_reg;
   logic [1:0]           rresp_reg;
   logic [31:0]          rdata_reg;
   logic [29:0]          ridx;
   lswd_pkg::lswd_ctl_s  rctl;
   lswd_pkg::lswd_st_s   rst_img;

   assign ridx = s_axil_araddr[31:2];

   always_comb begin
      rctl                     = '0;
      rctl.run_stop_key        = key_reg;
      rst_img                  = '0;
      rst_img.overflow_action_select = mode_reg;
      rst_img.overflow_status_bit    = status_reg;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         arready_reg <= 1'h1;
         rvalid_reg  <= 1'h0;
         rresp_reg   <= lswd_pkg::RESP_OKAY;
         rdata_reg   <= '0;
      end else if (s_axil_arvalid && arready_reg) begin
         arready_reg <= 1'h0;
         rvalid_reg  <= 1'h1;
         if (ridx == lswd_pkg::CTL_IDX) begin
            rdata_reg <= {24'h000000, rctl};
            rresp_reg <= lswd_pkg::RESP_OKAY;
         end else if (ridx == lswd_pkg::ST_IDX) begin
            rdata_reg <= {24'h000000, rst_img};
            rresp_reg <= lswd_pkg::RESP_OKAY;
         end else begin
            rdata_reg <= '0;
            rresp_reg <= lswd_pkg::RESP_SLVERR;
         end
      end else if (rvalid_reg && s_axil_rready) begin
         arready_reg <= 1'h1;
         rvalid_reg  <= 1'h0;
      end
   end

   assign s_axil_arready = arready_reg;
   assign s_axil_rvalid  = rvalid_reg;
   assign s_axil_rresp   = rresp_reg;
   assign s_axil_rdata   = rdata_reg;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_overflow;
      tick_rise && run && (count == lswd_pkg::CNT_MAX);
   endsequence

   sequence s_kick_only;
      kick && !ovf;
   endsequence

   sequence s_write_done;
      wr_go ##1 bvalid_reg;
   endsequence

   ovf_to_nmi_a: assert property (s_overflow and !mode_reg |=> nmi_req && !sys_reset_req)
      else $error("overflow in NMI mode did not raise NMI");

   ovf_to_rst_a: assert property (s_overflow and mode_reg |=> sys_reset_req && !nmi_req)
      else $error("overflow in reset mode did not raise reset");

   stop_holds_a: assert property (!run && !kick |=> $stable(count))
      else $error("counter moved while stopped");

   no_tick_hold_a: assert property (!tick_rise && !kick |=> $stable(count))
      else $error("counter moved without a tick");

   tick_step_a: assert property (tick_rise && run && !kick && count != lswd_pkg::CNT_MAX
                                 |=> count == $past(count) + lswd_pkg::CNT_W'(1))
      else $error("counter did not step on tick");

   kick_clear_a: assert property (s_kick_only |=> count == lswd_pkg::CNT_ZERO && !status_reg)
      else $error("kick did not clear counter and status");

   ovf_status_a: assert property (s_overflow |=> status_reg ##1 (status_reg || $past(kick)))
      else $error("overflow did not set status");

   wrap_restart_a: assert property (s_overflow and !kick |=> count == lswd_pkg::CNT_ZERO)
      else $error("counter did not restart after overflow");

   one_pulse_a: assert property (nmi_req || sys_reset_req |=> !nmi_req && !sys_reset_req)
      else $error("overflow request longer than one cycle");

   read_zero_a: assert property (rvalid_reg |-> rdata_reg[31:4] == 28'h0000000)
      else $error("reserved or kick bits read non-zero");

   reset_key_a: assert property (disable iff (1'b0) $fell(reset) |-> key_reg == lswd_pkg::KEY_STOP)
      else $error("key not stop value after reset");

   write_resp_a: assert property (s_write_done |-> !awready_reg && !wready_reg)
      else $error("write response without both channels taken");

endmodule : lswd_watchdog
`default_nettype wire
